// >>> core_status_pkg.sv
// Package for the core status register: field layout, reset value,
// bank-select encodings and the update record passed in by the core.
// Assumes a single 100 MHz core clock and a synchronous reset.
package core_status_pkg;

  // ==========================================================
  // Register map and field positions
  // ==========================================================
  localparam logic [2:0] STATUS_ADDR = 3'h0;
  localparam logic [2:0] BANK_ADDR   = 3'h1;
  localparam int BIT_CARRY    = 0;
  localparam int BIT_NIBBLE   = 1;
  localparam int BIT_ZERO     = 2;
  localparam int BIT_SLEEP_N  = 3;
  localparam int BIT_WDOG_N   = 4;
  localparam int BIT_RP_LO    = 5;
  localparam int BIT_RP_HI    = 6;
  localparam int BIT_IND_PAGE = 7;
  // Expiry and sleep bits read as one after power-up; the rest clear.
  localparam logic [7:0] STATUS_RESET = 8'h18;
  // Hardware owns the two power bits; software writes leave them alone.
  localparam logic [7:0] SW_WRITE_MASK = 8'he7;

  // ==========================================================
  // Addressing
  // ==========================================================
  localparam int OFFSET_W = 7;
  localparam int ADDR_W   = 9;

  typedef enum logic [2:0] {
    OP_NONE       = 3'b000,
    OP_ADD_W_FILE = 3'b001,
    OP_ADD_LIT    = 3'b010,
    OP_SUB_LIT    = 3'b011,
    OP_SUB_FILE   = 3'b100,
    OP_LOGIC      = 3'b101
  } alu_op_e;

  // Operation and operands of one ALU step as requested by the execution logic.
  typedef struct packed {
    alu_op_e    op;
    logic [7:0] a;
    logic [7:0] b;
  } alu_req_s;

  // Power management events, each a one-cycle pulse.
  typedef struct packed {
    logic clr_wdt;
    logic sleep;
    logic wdt_expire;
  } pwr_evt_s;

endpackage : core_status_pkg

// >>> core_status_flag_register.sv
// Core status register with arithmetic flags, watchdog and sleep bits and
// bank selection, plus the data-memory address former.
// Assumes the execution logic pulses events for one cycle and that
// software access does not coincide with an ALU flag update.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps

// Function
// - The indirect page bit picks bank 2 when one and bank 0 when zero.
// - The two direct page bits pick bank 3, 2, 1 or 0 for codes 11..00.
// - Each bank is 128 bytes so the in-bank offset is seven bits.
// - The expiry bit goes to one on power-up, watchdog clear and sleep.
// - The expiry bit goes to zero when the watchdog runs out.
// - The sleep bit goes to one on power-up and on watchdog clear.
// - The sleep bit goes to zero when the sleep instruction runs.
// - The zero flag shows whether each ALU result is zero.
// - For the four add and subtract ops the nibble flag shows bit 3 carry.
// - For those ops the carry flag shows the carry out of bit 7.
module core_status_flag_register
  import core_status_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Register port
  input  wire logic [2:0]          addr,
  input  wire logic [7:0]          wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic      [7:0]          rdata,
  // Execution and watchdog events
  input  wire alu_req_s            alu,
  input  wire pwr_evt_s            pwr,
  // Addressing
  input  wire logic [OFFSET_W-1:0] offset,
  input  wire logic                indirect,
  output logic      [ADDR_W-1:0]   mem_addr,
  output logic      [7:0]          alu_result,
  output logic      [7:0]          status
);

  // ==========================================================
  // ALU flag evaluation
  // ==========================================================
  function automatic logic is_arith(input alu_op_e op);
    is_arith = (op == OP_ADD_W_FILE) || (op == OP_ADD_LIT) ||
               (op == OP_SUB_LIT) || (op == OP_SUB_FILE);
  endfunction : is_arith

  // Direct bank code; the address former and the bank view share it.
  function automatic logic [1:0] direct_bank(input logic [7:0] st);
    direct_bank = {st[BIT_RP_HI], st[BIT_RP_LO]};
  endfunction : direct_bank

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;
  logic [7:0] st_q, st_d, res_q, res_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    // Subtraction is done as add of the two's complement, so carry set
    // means no borrow, as the instruction set expects.
    if ((alu.op == OP_SUB_LIT) || (alu.op == OP_SUB_FILE)) begin
      sum = {1'b0, alu.a} + {1'b0, ~alu.b} + 9'h001;
      nib = {1'b0, alu.a[3:0]} + {1'b0, ~alu.b[3:0]} + 5'h01;
    end else begin
      sum = {1'b0, alu.a} + {1'b0, alu.b};
      nib = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
    end
    res = (alu.op == OP_LOGIC) ? (alu.a & alu.b) : sum[7:0];
  end

  // ==========================================================
  // Status register next state
  // ==========================================================
  always_comb begin
    st_d  = st_q;
    res_d = res_q;
    if (wr && addr == STATUS_ADDR) begin
      st_d = (st_q & ~SW_WRITE_MASK) | (wdata & SW_WRITE_MASK);
    end
    if (alu.op != OP_NONE) begin
      res_d = res;
      st_d[BIT_ZERO] = (res == 8'h00);
      if (is_arith(alu.op)) begin
        st_d[BIT_NIBBLE] = nib[4];
        st_d[BIT_CARRY]  = sum[8];
      end
    end
    // Events win over software and each other: expiry last, so a timeout
    // coinciding with a clear is not lost.
    if (pwr.clr_wdt) begin
      st_d[BIT_WDOG_N]  = 1'b1;
      st_d[BIT_SLEEP_N] = 1'b1;
    end
    if (pwr.sleep) begin
      st_d[BIT_WDOG_N]  = 1'b1;
      st_d[BIT_SLEEP_N] = 1'b0;
    end
    if (pwr.wdt_expire) begin
      st_d[BIT_WDOG_N] = 1'b0;
    end
  end

  // ==========================================================
  // Address former and read port
  // ==========================================================
  always_comb begin
    if (indirect) begin
      // The pointer's own bank bit is not an input of this block, so
      // pointer access reaches only the lower half of each bank pair.
      addr_d = {st_d[BIT_IND_PAGE], 1'b0, offset};
    end else begin
      addr_d = {direct_bank(st_d), offset};
    end
    rdata_d = 8'h00;
    if (rd) begin
      case (addr)
        STATUS_ADDR: rdata_d = st_q;
        BANK_ADDR:   rdata_d = {6'h00, direct_bank(st_q)};
        default:     rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q    <= STATUS_RESET;
      res_q   <= 8'h00;
      addr_q  <= '0;
      rdata_q <= 8'h00;
    end else begin
      st_q    <= st_d;
      res_q   <= res_d;
      addr_q  <= addr_d;
      rdata_q <= rdata_d;
    end
  end

  assign status     = st_q;
  assign alu_result = res_q;
  assign mem_addr   = addr_q;
  assign rdata      = rdata_q;

  // ==========================================================
  // Checks
  // ==========================================================
  // These run without the reset guard, since they watch reset itself.
  a_reset_value: assert property (@(posedge clk)
    rst |=> status == STATUS_RESET)
    else $error("status not at power-up value after reset");

  a_reset_outputs: assert property (@(posedge clk)
    rst |=> mem_addr == 9'h000 && rdata == 8'h00)
    else $error("address or read data not cleared by reset");

  // ==========================================================
  // Checks: power bits
  // ==========================================================
  a_sleep_clears_sleep: assert property (@(posedge clk)
    disable iff (rst)
    pwr.sleep && !pwr.clr_wdt |=> !st_q[BIT_SLEEP_N])
    else $error("sleep did not clear sleep bit");

  a_clear_sets_both: assert property (@(posedge clk)
    disable iff (rst)
    pwr.clr_wdt && !pwr.sleep && !pwr.wdt_expire
      |=> st_q[BIT_WDOG_N] && st_q[BIT_SLEEP_N])
    else $error("watchdog clear did not set power bits");

  a_expiry_clears_flag: assert property (@(posedge clk)
    disable iff (rst)
    pwr.wdt_expire |=> !st_q[BIT_WDOG_N])
    else $error("expiry did not clear expiry bit");

  a_sleep_sets_expiry: assert property (@(posedge clk)
    disable iff (rst)
    pwr.sleep && !pwr.wdt_expire |=> st_q[BIT_WDOG_N])
    else $error("sleep did not set expiry bit");

  a_clear_sets_sleep: assert property (@(posedge clk)
    disable iff (rst)
    pwr.clr_wdt && !pwr.sleep |=> st_q[BIT_SLEEP_N])
    else $error("watchdog clear did not set sleep bit");

  a_sw_power_kept: assert property (@(posedge clk)
    disable iff (rst)
    wr && pwr == '0 |=>
      st_q[BIT_WDOG_N:BIT_SLEEP_N] == $past(st_q[BIT_WDOG_N:BIT_SLEEP_N]))
    else $error("software write changed power bits");

  // ==========================================================
  // Checks: result flags
  // ==========================================================
  a_zero_flag_ok: assert property (@(posedge clk)
    disable iff (rst)
    alu.op != OP_NONE |=> st_q[BIT_ZERO] == (res_q == 8'h00))
    else $error("zero flag mismatch");

  a_add_zero: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_ADD_W_FILE |=>
      st_q[BIT_ZERO] == (($past(alu.a) + $past(alu.b)) == 8'h00))
    else $error("zero flag wrong after add");

  a_sub_zero: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_SUB_FILE |=>
      st_q[BIT_ZERO] == ($past(alu.a) == $past(alu.b)))
    else $error("zero flag wrong after subtract");

  a_logic_zero: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_LOGIC |=>
      st_q[BIT_ZERO] == (($past(alu.a) & $past(alu.b)) == 8'h00))
    else $error("zero flag wrong after logic op");

  a_logic_result: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_LOGIC |=> alu_result == ($past(alu.a) & $past(alu.b)))
    else $error("logic result mismatch");

  a_nibble_carry_ok: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_ADD_LIT |=>
      st_q[BIT_NIBBLE] == ($past(alu.a[3:0]) + $past(alu.b[3:0]) > 15))
    else $error("nibble carry mismatch");

  a_add_file_nibble: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_ADD_W_FILE |=>
      st_q[BIT_NIBBLE] == ($past(alu.a[3:0]) + $past(alu.b[3:0]) > 15))
    else $error("nibble carry wrong after add");

  a_sub_nibble: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_SUB_LIT |=>
      st_q[BIT_NIBBLE] == ($past(alu.a[3:0]) >= $past(alu.b[3:0])))
    else $error("nibble borrow wrong after subtract");

  a_sub_file_nibble: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_SUB_FILE |=>
      st_q[BIT_NIBBLE] == ($past(alu.a[3:0]) >= $past(alu.b[3:0])))
    else $error("nibble borrow wrong after file subtract");

  a_carry_out_ok: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_ADD_W_FILE |=>
      st_q[BIT_CARRY] == ({1'b0, $past(alu.a)} + $past(alu.b) > 255))
    else $error("carry mismatch");

  a_add_lit_carry: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_ADD_LIT |=>
      st_q[BIT_CARRY] == ({1'b0, $past(alu.a)} + $past(alu.b) > 255))
    else $error("carry wrong after literal add");

  a_sub_carry: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_SUB_FILE |=>
      st_q[BIT_CARRY] == ($past(alu.a) >= $past(alu.b)))
    else $error("borrow wrong after file subtract");

  a_sub_lit_carry: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_SUB_LIT |=>
      st_q[BIT_CARRY] == ($past(alu.a) >= $past(alu.b)))
    else $error("borrow wrong after literal subtract");

  a_logic_keeps_carry: assert property (@(posedge clk)
    disable iff (rst)
    alu.op == OP_LOGIC && !wr |=>
      st_q[BIT_NIBBLE:BIT_CARRY] == $past(st_q[BIT_NIBBLE:BIT_CARRY]))
    else $error("logic op changed carry flags");

  // ==========================================================
  // Checks: addressing and register port
  // ==========================================================
  a_direct_bank_sel: assert property (@(posedge clk)
    disable iff (rst)
    !indirect && alu.op == OP_NONE && !wr |=>
      mem_addr[8:7] == st_q[BIT_RP_HI:BIT_RP_LO])
    else $error("direct bank mismatch");

  a_indirect_bank: assert property (@(posedge clk)
    disable iff (rst)
    indirect && !wr |=> mem_addr[8] == st_q[BIT_IND_PAGE])
    else $error("indirect bank mismatch");

  a_indirect_low_half: assert property (@(posedge clk)
    disable iff (rst)
    indirect |=> !mem_addr[7])
    else $error("indirect address left the lower half");

  a_offset_kept: assert property (@(posedge clk)
    disable iff (rst)
    1'b1 |=> mem_addr[OFFSET_W-1:0] == $past(offset))
    else $error("offset lost");

  a_write_lands: assert property (@(posedge clk)
    disable iff (rst)
    wr && addr == STATUS_ADDR && alu.op == OP_NONE && pwr == '0 |=>
      st_q[BIT_IND_PAGE:BIT_RP_LO] == $past(wdata[7:5]))
    else $error("bank bits not written");

  a_bank_view: assert property (@(posedge clk)
    disable iff (rst)
    rd && addr == BANK_ADDR |=>
      rdata == {6'h00, $past(st_q[BIT_RP_HI:BIT_RP_LO])})
    else $error("bank view read mismatch");

  c_sleep: cover property (@(posedge clk) pwr.sleep);
  c_expire: cover property (@(posedge clk) pwr.wdt_expire);
  c_sub_borrow: cover property (@(posedge clk)
    alu.op == OP_SUB_FILE ##1 !st_q[BIT_CARRY]);
  c_indirect_hi: cover property (@(posedge clk)
    indirect && st_q[BIT_IND_PAGE]);
  c_bank_three: cover property (@(posedge clk)
    !indirect && st_q[BIT_RP_HI] && st_q[BIT_RP_LO]);

endmodule : core_status_flag_register

// >>> core_status_flag_register_tb.sv
// Self-checking bench for the core status register.
// Assumes the bench drives every port itself on one 100 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module core_status_flag_register_tb
  import core_status_pkg::*;
;
  // ========================================
  // Stimulus and observed signals
  // ========================================
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  alu_req_s    alu = '0;
  pwr_evt_s    pwr = '0;
  logic [6:0]  offset = 7'h55;
  logic        indirect = 1'b0;
  logic [8:0]  mem_addr;
  logic [7:0]  alu_result;
  logic [7:0]  status;
  int          n_fail = 0;
  int          num_checks = 0;

  always #5 clk = ~clk;

  core_status_flag_register i_dut (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .alu(alu), .pwr(pwr),
    .offset(offset), .indirect(indirect), .mem_addr(mem_addr),
    .alu_result(alu_result), .status(status));

  // ========================================
  // Bus and event helpers
  // ========================================
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0; #1;
  endtask : wr_reg

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0; #1;
    `CHK(rdata, e)
  endtask : rd_chk

  // Flags are checked as {zero, nibble carry, carry}.
  task automatic alu_op(input alu_op_e op, input logic [7:0] a, b, r,
                        input logic [2:0] f);
    @(posedge clk); alu <= '{op, a, b};
    @(posedge clk); alu <= '0; #1;
    `CHK(alu_result, r)
    `CHK(status[2:0], f)
  endtask : alu_op

  task automatic pwr_evt(input logic [2:0] ev, input logic [1:0] e);
    @(posedge clk); pwr <= ev;
    @(posedge clk); pwr <= '0; #1;
    `CHK(status[4:3], e)
  endtask : pwr_evt

  // ========================================
  // Scenarios
  // ========================================
  task automatic t_banks();
    for (int i = 0; i < 4; i++) begin
      wr_reg(3'h0, {1'b0, 2'(i), 5'h00});
      `CHK(mem_addr, {2'(i), 7'h55})
    end
    @(posedge clk); indirect <= 1'b1; offset <= 7'h2a;
    for (int i = 0; i < 2; i++) begin
      wr_reg(3'h0, {1'(i), 7'h00});
      `CHK(mem_addr[8], 1'(i))
      `CHK(mem_addr[6:0], 7'h2a)
    end
  endtask : t_banks

  task automatic t_power();
    pwr_evt(3'b010, 2'b10);
    wr_reg(3'h0, 8'hff);
    rd_chk(3'h0, 8'hf7);
    rd_chk(3'h1, 8'h03);
    wr_reg(3'h1, 8'h00);
    rd_chk(3'h0, 8'hf7);
    pwr_evt(3'b001, 2'b00);
    pwr_evt(3'b100, 2'b11);
    pwr_evt(3'b101, 2'b01);
    pwr_evt(3'b010, 2'b10);
    rd_chk(3'h5, 8'h00);
  endtask : t_power

  task automatic t_alu();
    alu_op(OP_ADD_LIT, 8'h0f, 8'h01, 8'h10, 3'b010);
    alu_op(OP_ADD_W_FILE, 8'hff, 8'h01, 8'h00, 3'b111);
    alu_op(OP_SUB_LIT, 8'h05, 8'h05, 8'h00, 3'b111);
    alu_op(OP_SUB_FILE, 8'h10, 8'h01, 8'h0f, 3'b001);
    alu_op(OP_LOGIC, 8'hf0, 8'h0f, 8'h00, 3'b101);
    alu_op(OP_ADD_W_FILE, 8'h88, 8'h88, 8'h10, 3'b011);
  endtask : t_alu

  // ========================================
  // Closing
  // ========================================
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk); #1;
    `CHK(status, 8'h18)
    `CHK(mem_addr, 9'h055)
    t_banks();
    t_power();
    t_alu();
    complete_run();
  end
endmodule : core_status_flag_register_tb
